//--- sfd_fan_ctrl.sv
// Control logic of a single-phase fan driver with Wishbone registers.
// Assumes pins and comparator flags are asynchronous; one clock domain.
// Operation
// - Tach changes state at every commutation, following the Hall state.
// - Stall at south pole: B held low, A pulsed with on/off timing.
// - Stall at north pole: A held low, B pulsed with on/off timing.
// - Drive-on window awaiting Hall change lasts 420 ms.
// - After stall, outputs off ten times the on window, then retry.
// - Speed input low longer than 65 ms: outputs off, standby.
// - Standby clears pending off window; next high starts fresh on window.
// - Tach pull-down released in standby.
// - Hall path given 100 us to settle after leaving standby.
// - Active output gated by speed input so duty follows input.
// - Output duty from 10 to 100 percent at 25 kHz input.
// - Speed input held high gives full duty.
// - Coil current ramped softly over 200 us at each commutation.
// - Overvoltage flag switches all outputs off and enters standby.
// - Overvoltage trips near 21 V, releases only below 20 V.
// - Thermal flag disables outputs; resume after 25 degree drop.
//
// The address map and the Wishbone interface to the registers were decided locally.
`default_nettype none

module sfd_fan_ctrl
	import sfd_pkg::*;
#(
	parameter logic [31:0] TON_CYC_P    = TON_CYC,
	parameter logic [31:0] TOFF_CYC_P   = TOFF_CYC,
	parameter logic [31:0] STBY_CYC_P   = STBY_CYC,
	parameter logic [31:0] SETTLE_CYC_P = SETTLE_CYC,
	parameter logic [31:0] TSW_CYC_P    = TSW_CYC
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Sensor and speed pins
	input  wire logic        hall_i,
	input  wire logic        pwm_i,
	// Protection comparators
	input  wire logic        ov_trip_i,
	input  wire logic        ov_release_i,
	input  wire logic        th_trip_i,
	input  wire logic        th_release_i,
	// Bridge drive
	output logic             drive_out_a_o,
	output logic             drive_out_b_o,
	// Open-drain tachometer
	output logic             tach_out_o,
	output logic             tach_out_oe_o
);

	localparam logic [31:0] STEP_CYC = (TSW_CYC_P >> 4) == 32'h0 ? 32'h1 : (TSW_CYC_P >> 4);

	// Input synchronisers: three stages, change taken when stages two and three agree
	logic [5:0] raw_in;
	logic [5:0] s1_r;
	logic [5:0] s2_r;
	logic [5:0] s3_r;
	logic [5:0] filt_r;

	assign raw_in = {th_release_i, th_trip_i, ov_release_i, ov_trip_i, pwm_i, hall_i};

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sync
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					s1_r[gi]   <= 1'b0;
					s2_r[gi]   <= 1'b0;
					s3_r[gi]   <= 1'b0;
					filt_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= raw_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					if (s2_r[gi] == s3_r[gi]) begin
						filt_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic hall_f;
	logic pwm_f;
	assign hall_f = filt_r[0];
	assign pwm_f  = filt_r[1];

	// Control register
	logic        en_r;
	logic        wb_req;
	logic        wb_ack_r;
	logic [31:0] wb_dat_r;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;

	// Fault latches with hysteresis; a trip outranks a release
	logic ov_lat_r;
	logic th_lat_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ov_lat_r <= 1'b0;
		end else if (filt_r[2]) begin
			ov_lat_r <= 1'b1;
		end else if (filt_r[3]) begin
			ov_lat_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			th_lat_r <= 1'b0;
		end else if (filt_r[4]) begin
			th_lat_r <= 1'b1;
		end else if (filt_r[5]) begin
			th_lat_r <= 1'b0;
		end
	end

	// Speed input low-time counter, saturating
	logic [31:0] low_cnt_r;
	logic        pwm_idle;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			low_cnt_r <= 32'h0;
		end else if (pwm_f) begin
			low_cnt_r <= 32'h0;
		end else if (low_cnt_r != STBY_CYC_P) begin
			low_cnt_r <= low_cnt_r + 32'h1;
		end
	end
	assign pwm_idle = (low_cnt_r == STBY_CYC_P);

	logic fault;
	logic stop;
	logic go_run;
	assign fault  = ov_lat_r || th_lat_r;
	assign stop   = fault || !en_r || pwm_idle;
	assign go_run = pwm_f && !fault && en_r;

	// Hall debounce and commutation event
	sfd_state_type st_r;
	logic          hall_st_r;
	logic [7:0]    deb_cnt_r;
	logic          comm;
	logic          spinning;
	logic [31:0]   cnt_r;
	logic          settle_done;
	assign spinning    = (st_r == ST_RUN) || (st_r == ST_LOCKOFF);
	assign settle_done = (st_r == ST_SETTLE) && !stop && (cnt_r == SETTLE_CYC_P - 32'h1);
	assign comm = spinning && (hall_f != hall_st_r) && (deb_cnt_r == HALL_DEB_CYC - 8'h1);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hall_st_r <= 1'b0;
			deb_cnt_r <= 8'h0;
		end else if (settle_done) begin
			hall_st_r <= hall_f;
			deb_cnt_r <= 8'h0;
		end else if (!spinning || hall_f == hall_st_r) begin
			deb_cnt_r <= 8'h0;
		end else if (comm) begin
			hall_st_r <= hall_f;
			deb_cnt_r <= 8'h0;
		end else begin
			deb_cnt_r <= deb_cnt_r + 8'h1;
		end
	end

	// Main sequence: standby, Hall settling, run with lock watch, lock off
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r  <= ST_STANDBY;
			cnt_r <= 32'h0;
		end else begin
			case (st_r)
				ST_STANDBY: begin
					cnt_r <= 32'h0;
					if (go_run) begin
						st_r <= ST_SETTLE;
					end
				end
				ST_SETTLE: begin
					if (stop) begin
						st_r  <= ST_STANDBY;
						cnt_r <= 32'h0;
					end else if (settle_done) begin
						st_r  <= ST_RUN;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_RUN: begin
					if (stop) begin
						st_r  <= ST_STANDBY;
						cnt_r <= 32'h0;
					end else if (comm) begin
						cnt_r <= 32'h0;
					end else if (cnt_r == TON_CYC_P - 32'h1) begin
						st_r  <= ST_LOCKOFF;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				ST_LOCKOFF: begin
					if (stop) begin
						st_r  <= ST_STANDBY;
						cnt_r <= 32'h0;
					end else if (cnt_r == TOFF_CYC_P - 32'h1) begin
						st_r  <= ST_RUN;
						cnt_r <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				default: begin
					st_r  <= ST_STANDBY;
					cnt_r <= 32'h0;
				end
			endcase
		end
	end

	// Soft commutation: dithered drive ramps to full over the switch time
	logic [4:0]  ramp_lvl_r;
	logic [31:0] ramp_sub_r;
	logic [3:0]  dither_r;
	logic        ramp_ok;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ramp_lvl_r <= RAMP_STEPS;
			ramp_sub_r <= 32'h0;
		end else if (comm || settle_done) begin
			ramp_lvl_r <= 5'h0;
			ramp_sub_r <= 32'h0;
		end else if (ramp_lvl_r != RAMP_STEPS) begin
			if (ramp_sub_r == STEP_CYC - 32'h1) begin
				ramp_lvl_r <= ramp_lvl_r + 5'h1;
				ramp_sub_r <= 32'h0;
			end else begin
				ramp_sub_r <= ramp_sub_r + 32'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dither_r <= 4'h0;
		end else begin
			dither_r <= dither_r + 4'h1;
		end
	end
	assign ramp_ok = ({1'b0, dither_r} < ramp_lvl_r);

	// Bridge and tach outputs, registered
	logic drive_a_r;
	logic drive_b_r;
	logic tach_oe_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			drive_a_r <= 1'b0;
			drive_b_r <= 1'b0;
			tach_oe_r <= 1'b0;
		end else begin
			// Lock off and standby leave both sides low
			drive_a_r <= (st_r == ST_RUN) && hall_st_r && pwm_f && ramp_ok;
			drive_b_r <= (st_r == ST_RUN) && !hall_st_r && pwm_f && ramp_ok;
			// Tach follows the commutation state, not the speed gating
			tach_oe_r <= spinning && hall_st_r;
		end
	end
	assign drive_out_a_o = drive_a_r;
	assign drive_out_b_o = drive_b_r;
	assign tach_out_o    = 1'b0;
	assign tach_out_oe_o = tach_oe_r;

	// Wishbone slave: one wait state, unmapped reads give zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_r <= CTRL_EN_RST;
		end else if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_CTRL) begin
			en_r <= wb_dat_i[CTRL_EN_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= 32'h0;
		end else begin
			wb_ack_r <= wb_req;
			wb_dat_r <= 32'h0;
			if (wb_req && !wb_we_i) begin
				case (wb_adr_i)
					REG_CTRL: begin
						wb_dat_r[CTRL_EN_BIT] <= en_r;
					end
					REG_STATUS: begin
						wb_dat_r[STAT_STATE_LSB +: 2] <= st_r;
						wb_dat_r[STAT_OV_BIT]         <= ov_lat_r;
						wb_dat_r[STAT_TH_BIT]         <= th_lat_r;
						wb_dat_r[STAT_HALL_BIT]       <= hall_st_r;
						wb_dat_r[STAT_IDLE_BIT]       <= pwm_idle;
					end
					default: begin
						wb_dat_r <= 32'h0;
					end
				endcase
			end
		end
	end
	assign wb_ack_o = wb_ack_r;
	assign wb_dat_o = wb_dat_r;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_drive_exclusive: assert property (!(drive_out_a_o && drive_out_b_o))
		else $error("both bridge outputs high");
	a_standby_off: assert property (st_r == ST_STANDBY |=> !drive_out_a_o && !drive_out_b_o)
		else $error("drive active in standby");
	a_standby_tach: assert property (st_r == ST_STANDBY |=> !tach_out_oe_o)
		else $error("tach pulled in standby");
	a_ov_standby: assert property (ov_lat_r && st_r != ST_STANDBY |=> st_r == ST_STANDBY)
		else $error("overvoltage did not force standby");
	a_ton_expiry: assert property (st_r == ST_RUN && !stop && !comm
		&& cnt_r == TON_CYC_P - 32'h1 |=> st_r == ST_LOCKOFF && cnt_r == 32'h0)
		else $error("lock window did not expire into off");
	a_toff_retry: assert property (st_r == ST_LOCKOFF && !stop
		&& cnt_r == TOFF_CYC_P - 32'h1 |=> st_r == ST_RUN && cnt_r == 32'h0)
		else $error("off window did not retry");
	a_pwm_gate: assert property (!pwm_f |=> !drive_out_a_o && !drive_out_b_o)
		else $error("drive while speed input low");
	a_comm_restart: assert property (comm && st_r == ST_RUN && !stop |=> cnt_r == 32'h0)
		else $error("commutation did not restart lock timer");
	a_tach_follow: assert property (spinning |=> tach_out_oe_o == $past(hall_st_r))
		else $error("tach not following commutation");
	a_settle_hold: assert property (st_r == ST_SETTLE && cnt_r < SETTLE_CYC_P - 32'h1
		|=> st_r != ST_RUN)
		else $error("run entered before settling");
	a_fault_release: assert property ($fell(ov_lat_r) |-> $past(filt_r[3]) && !$past(filt_r[2]))
		else $error("overvoltage released without release level");

	c_lock_off: cover property (st_r == ST_RUN ##1 st_r == ST_LOCKOFF);
	c_standby: cover property (st_r == ST_RUN ##1 st_r == ST_STANDBY);
	c_commutate: cover property (st_r == ST_RUN && comm);

endmodule : sfd_fan_ctrl

`default_nettype wire

//--- sfd_fan_model.sv
// Fan motor and speed source model for the fan drive bench.
// Assumes the bench clock; rotor and source step on its rising edge.
`default_nettype none

module sfd_fan_model #(
	parameter int PER  = 40,
	parameter int HALF = 300
) (
	// Clock and controls
	input  wire logic       clk_i,
	input  wire logic       spin_i,
	input  wire logic       pole_i,
	input  wire logic [7:0] duty_i,
	// Pins
	output logic            hall_o,
	output logic            pwm_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int unsigned pcnt = 0;
	int unsigned hcnt = 0;
	// Scaled period, a real one would trip the shortened idle filter
	always @(posedge clk_i) begin
		pcnt <= (pcnt == PER - 1) ? 0 : pcnt + 1;
		pwm_o <= (pcnt < duty_i);
	end
	// Rotor inertia: turns while spin_i, else parks at pole_i
	always @(posedge clk_i) begin
		if (!spin_i) begin
			hcnt <= 0;
			hall_o <= pole_i;
		end else if (hcnt == HALF - 1) begin
			hcnt <= 0;
			hall_o <= !hall_o;
		end else begin
			hcnt <= hcnt + 1;
		end
	end
endmodule : sfd_fan_model

`default_nettype wire

//--- sfd_pkg.sv
// Constants, register map and state codes of the fan drive control.
// Assumes a single 200 MHz clock and a synchronous active-high reset.
`default_nettype none

package sfd_pkg;

	// Clock rate
	localparam int unsigned CLK_HZ          = 200_000_000;

	// Timing figures in their own units
	localparam int unsigned TON_MS          = 420;
	localparam int unsigned TOFF_RATIO      = 10;
	localparam int unsigned STBY_MS         = 65;
	localparam int unsigned SETTLE_US       = 100;
	localparam int unsigned TSW_US          = 200;

	// Derived cycle counts
	localparam logic [31:0] TON_CYC         = 32'(TON_MS * (CLK_HZ / 1000));
	localparam logic [31:0] TOFF_CYC        = 32'(TON_MS * TOFF_RATIO * (CLK_HZ / 1000));
	localparam logic [31:0] STBY_CYC        = 32'(STBY_MS * (CLK_HZ / 1000));
	localparam logic [31:0] SETTLE_CYC      = 32'(SETTLE_US * (CLK_HZ / 1_000_000));
	localparam logic [31:0] TSW_CYC         = 32'(TSW_US * (CLK_HZ / 1_000_000));
	localparam logic [7:0]  HALL_DEB_CYC    = 8'h10;
	localparam logic [4:0]  RAMP_STEPS      = 5'h10;

	// Register offsets
	localparam logic [3:0]  REG_CTRL        = 4'h0;
	localparam logic [3:0]  REG_STATUS      = 4'h4;

	// Control fields
	localparam int unsigned CTRL_EN_BIT     = 0;
	localparam logic        CTRL_EN_RST     = 1'b1;

	// Status fields
	localparam int unsigned STAT_STATE_LSB  = 0;
	localparam int unsigned STAT_OV_BIT     = 2;
	localparam int unsigned STAT_TH_BIT     = 3;
	localparam int unsigned STAT_HALL_BIT   = 4;
	localparam int unsigned STAT_IDLE_BIT   = 5;

	typedef enum logic [1:0] {
		ST_STANDBY = 2'b00,
		ST_SETTLE  = 2'b01,
		ST_RUN     = 2'b10,
		ST_LOCKOFF = 2'b11
	} sfd_state_type;

endpackage : sfd_pkg

`default_nettype wire

//--- single_phase_fan_drive_control_bench.sv
// Self-checking bench of the fan drive control with its partner model.
// Assumes the design's shortened counts given at the instance.
`default_nettype none

module single_phase_fan_drive_control_bench
	import sfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [31:0] TON = 32'h320, TOFF = 32'h1f40;
	logic clk_i = 1'b0, rst_i = 1'b1, cyc_o = 1'b0, we = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic ack, hall, pwm, a_o, b_o, tach, oe;
	logic [1:0] trip = 2'b00, rel = 2'b11;
	logic spin = 1'b0, pole = 1'b1;
	logic [7:0] duty = 8'h28;
	int failures = 0, checks_done = 0, cyc = 0;
	always #2.5 clk_i = ~clk_i;
	sfd_fan_ctrl #(.TON_CYC_P(TON), .TOFF_CYC_P(TOFF), .STBY_CYC_P(32'h64),
		.SETTLE_CYC_P(32'h14), .TSW_CYC_P(32'h20)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc_o), .wb_stb_i(cyc_o), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .hall_i(hall), .pwm_i(pwm),
		.ov_trip_i(trip[0]), .ov_release_i(rel[0]), .th_trip_i(trip[1]),
		.th_release_i(rel[1]), .drive_out_a_o(a_o), .drive_out_b_o(b_o),
		.tach_out_o(tach), .tach_out_oe_o(oe));
	sfd_fan_model mdl (.clk_i(clk_i), .spin_i(spin), .pole_i(pole), .duty_i(duty),
		.hall_o(hall), .pwm_o(pwm));
	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : summarize
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			failures++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
	endtask : ticks
	// Held until ack is sampled, released one cycle before the next request
	task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		we <= w;
		adr <= ad;
		wdat <= d;
		sel <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = rdat;
		cyc_o <= 1'b0;
	endtask : wb
	task automatic wait_st(input logic [1:0] s, input int lim);
		int n;
		n = 0;
		do begin
			wb(1'b0, REG_STATUS, 32'h0, 4'hf);
			n++;
		end while (rd[1:0] !== s && n < lim);
		chk("state", {30'h0, s}, {30'h0, rd[1:0]});
	endtask : wait_st
	task automatic t_regs();
		wb(1'b0, REG_CTRL, 32'h0, 4'hf);
		chk("ctrl reset", 32'h1, rd);
		wb(1'b1, REG_CTRL, 32'h0, 4'he);
		wb(1'b0, REG_CTRL, 32'h0, 4'hf);
		chk("ctrl sel", 32'h1, rd);
		wb(1'b1, 4'h8, 32'hffffffff, 4'hf);
		wb(1'b0, 4'h8, 32'h0, 4'hf);
		chk("unmapped", 32'h0, rd);
		// Enable off forces standby, then back on for the later scenarios
		wb(1'b1, REG_CTRL, 32'h0, 4'h1);
		wb(1'b0, REG_CTRL, 32'h0, 4'hf);
		chk("ctrl off", 32'h0, rd);
		wait_st(ST_STANDBY, 4);
		wb(1'b1, REG_CTRL, 32'h1, 4'h1);
	endtask : t_regs
	task automatic t_spin();
		int c;
		spin <= 1'b1;
		wait_st(ST_RUN, 30);
		repeat (4) begin
			@(hall);
			ticks(21);
			c = 0;
			// Just after commutation the ramp must keep the duty well below full
			repeat (16) begin
				@(posedge clk_i);
				c += int'(a_o | b_o);
			end
			chk("soft start", 32'h1, 32'(c < 12));
			ticks(43);
			chk("drive", {28'h0, 1'b0, hall, !hall, hall}, {28'h0, tach, a_o, b_o, oe});
		end
		wait_st(ST_RUN, 1);
	endtask : t_spin
	task automatic t_duty(input logic [7:0] d);
		int c;
		c = 0;
		duty <= d;
		@(hall);
		ticks(60);
		repeat (200) begin
			@(posedge clk_i);
			c += int'(a_o | b_o);
		end
		chk("duty", 32'h1, 32'(c >= d * 5 - 8 && c <= d * 5 + 8));
	endtask : t_duty
	task automatic t_lock(input logic p);
		int hi, lo, n;
		logic act;
		duty <= 8'h0;
		spin <= 1'b0;
		pole <= p;
		wait_st(ST_STANDBY, 80);
		chk("hall state", {31'h0, p}, {31'h0, rd[STAT_HALL_BIT]});
		duty <= 8'h28;
		hi = 0;
		lo = 0;
		n = 0;
		act = 1'b0;
		while (lo < 100 && n < 2000) begin
			@(posedge clk_i);
			n++;
			act = p ? a_o : b_o;
			chk("idle side", 32'h0, {31'h0, p ? b_o : a_o});
			if (act === 1'b1) begin
				hi = n;
				lo = 0;
			end else
				lo++;
		end
		chk("on window", 32'h1, 32'(hi > TON && hi < TON + 60));
		while (act !== 1'b1 && lo < 12000) begin
			@(posedge clk_i);
			lo++;
			act = p ? a_o : b_o;
		end
		chk("off window", 32'h1, 32'(lo > TOFF - 10 && lo < TOFF + 60));
	endtask : t_lock
	task automatic t_quick();
		pole <= 1'b1;
		wait_st(ST_LOCKOFF, 500);
		duty <= 8'h0;
		wait_st(ST_STANDBY, 60);
		chk("idle flag", 32'h1, {31'h0, rd[STAT_IDLE_BIT]});
		chk("standby pins", 32'h0, {29'h0, a_o, b_o, oe});
		duty <= 8'h28;
		ticks(10);
		chk("settling", 32'h0, {30'h0, a_o, b_o});
		wait_st(ST_RUN, 20);
	endtask : t_quick
	task automatic t_fault(input int i);
		spin <= 1'b1;
		wait_st(ST_RUN, 30);
		trip[i] <= 1'b1;
		rel[i] <= 1'b0;
		ticks(5);
		trip[i] <= 1'b0;
		ticks(10);
		chk("fault off", 32'h0, {30'h0, a_o, b_o});
		wait_st(ST_STANDBY, 2);
		chk("latch", 32'h1, {31'h0, rd[STAT_OV_BIT + i]});
		ticks(100);
		wait_st(ST_STANDBY, 1);
		rel[i] <= 1'b1;
		wait_st(ST_RUN, 30);
	endtask : t_fault
	initial begin
		ticks(8);
		rst_i <= 1'b0;
		t_regs();
		t_spin();
		t_duty(8'h4);
		t_duty(8'h14);
		t_duty(8'h28);
		t_lock(1'b1);
		t_lock(1'b0);
		t_quick();
		t_fault(0);
		t_fault(1);
		summarize();
	end
endmodule : single_phase_fan_drive_control_bench

`default_nettype wire
